// ### include/zsd_pkg.sv
// Constants and types shared by the zero, suppress and display mode block
package zsd_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] ADR_CMD    = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_RDG    = 8'h08;
   localparam logic [7:0] ADR_BASE   = 8'h0C;
   localparam logic [7:0] ADR_OFS    = 8'h10;
   // Command word layout: opcode and parameter
   localparam int OP_LSB = 8;
   localparam int OP_W   = 4;
   localparam int PAR_W  = 4;
   // Opcodes
   localparam logic [3:0] OP_FUNC  = 4'h1;
   localparam logic [3:0] OP_RANGE = 4'h2;
   localparam logic [3:0] OP_CHECK = 4'h3;
   localparam logic [3:0] OP_CORR  = 4'h4;
   localparam logic [3:0] OP_SUPP  = 4'h5;
   localparam logic [3:0] OP_DISP  = 4'h6;
   localparam logic [3:0] OP_TRIG  = 4'h7;
   localparam logic [3:0] OP_CLEAR = 4'h8;
   // Parameter values
   localparam logic [3:0] PAR_OFF = 4'h0;
   localparam logic [3:0] PAR_ON  = 4'h1;
   // Range codes
   localparam logic [3:0] RNG_AUTO   = 4'h0;
   localparam logic [3:0] RNG_LOW    = 4'h1;
   localparam logic [3:0] RNG_HIGH   = 4'hB;
   localparam logic [3:0] RNG_FREEZE = 4'hC;
   // Function code of the voltage-to-current resistance mode
   localparam logic [2:0] FUNC_VI = 3'h5;
   localparam logic [2:0] FUNC_MAX = 3'h5;
   // Full-scale derivation: 100 V basis, 10,000 displayed counts
   localparam int VI_BASIS_V      = 100;
   localparam int VI_BASIS_EXP    = 2;
   localparam int DISP_COUNTS     = 10000;
   localparam int FS_MANT         = 2;
   localparam int CUR_EXP_TOP     = 13;
   localparam int VI_EXP_MIN      = 5;
   // Status register bit positions
   localparam int ST_CHECK  = 0;
   localparam int ST_CORR   = 1;
   localparam int ST_SUPP   = 2;
   localparam int ST_ARM    = 3;
   localparam int ST_SRC    = 4;
   localparam int ST_READY  = 5;
   localparam int ST_OVR    = 6;
   localparam int ST_RMODE  = 8;
   localparam int ST_RNG    = 12;
   localparam int ST_FUNC   = 16;
   localparam int ST_TRIG   = 20;
   // Readiness wait states
   typedef enum logic [3:0] {
      ZSD_IDLE  = 4'h1,
      ZSD_WCONV = 4'h2,
      ZSD_WFE   = 4'h4,
      ZSD_WRNG  = 4'h8
   } zsd_wait_e;
endpackage : zsd_pkg

// ### rtl/zsd_range_calc.sv
// Full-scale figures of the active range
`timescale 1ns/1ps
`default_nettype none
module zsd_range_calc #(
   parameter int DW = 24
) (
   // Active range
   input  wire logic [3:0]    rng_in,
   // Derived figures
   output logic [4:0]         vi_exp_out,
   output logic signed [DW-1:0] fs_lim_out
);
   localparam int FS_COUNTS = zsd_pkg::FS_MANT * zsd_pkg::DISP_COUNTS;
   int e;

   // Ohms decade = volt basis decade minus current decade, 2 x 10^e
   always_comb
   begin
      e = zsd_pkg::VI_BASIS_EXP + zsd_pkg::CUR_EXP_TOP - int'(rng_in);
      if (e < zsd_pkg::VI_EXP_MIN)
      begin
         e = zsd_pkg::VI_EXP_MIN;
      end
      vi_exp_out = e[4:0];
      fs_lim_out = FS_COUNTS[DW-1:0];
   end
endmodule : zsd_range_calc
`default_nettype wire

// ### rtl/zsd_top.sv
// Zero check/correct, range, baseline suppression and display mode block
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module zsd_top #(
   parameter int DW = 24
) (
   // Clock, reset, enable
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          ce_in,
   // Register port
   input  wire logic [7:0]    addr_in,
   input  wire logic [31:0]   wr_data_in,
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   output logic [31:0]        rd_data_out,
   // Converter and front end
   input  wire logic          conv_done_in,
   input  wire logic [DW-1:0] conv_data_in,
   input  wire logic          fe_setup_done_in,
   input  wire logic          rng_setup_done_in,
   // Mode state
   output logic               zero_check_out,
   output logic               offset_correct_out,
   output logic               suppress_out,
   output logic               show_source_out,
   output logic [3:0]         range_out,
   output logic [4:0]         vi_exp_out,
   output logic               ready_out,
   // Readings
   output logic [DW-1:0]      reading_out,
   output logic               reading_vld_out,
   output logic               overrange_out,
   output logic               range_up_out
);
   typedef struct packed {
      zsd_pkg::zsd_wait_e  wt;
      logic                chk;
      logic                cor;
      logic                cor_arm;
      logic                sup;
      logic                sup_arm;
      logic                src;
      logic [3:0]          rmode;
      logic [3:0]          rng;
      logic [2:0]          func;
      logic [2:0]          trig;
      logic [3:0]          base_rng;
      logic signed [DW-1:0] ofs;
      logic signed [DW-1:0] base;
      logic signed [DW-1:0] rdg;
      logic                vld;
      logic                ovr;
      logic                rup;
      logic [4:0]          vexp;
      logic [31:0]         rdata;
   } zsd_state_s;

   zsd_state_s            st_ff;
   zsd_state_s            nxt_st;
   logic [4:0]            calc_exp;
   logic signed [DW-1:0]  fs_lim;
   logic [3:0]            op;
   logic [3:0]            par;
   logic                  cmd;
   logic                  meter_cmd;
   logic signed [DW-1:0]  corr;
   logic signed [DW-1:0]  res;
   logic signed [DW-1:0]  mag;
   logic                  over;
   logic                  auto_up;
   logic [31:0]           status;

   zsd_range_calc #(
      .DW(DW)
   ) u_calc (
      .rng_in    (st_ff.rng),
      .vi_exp_out(calc_exp),
      .fs_lim_out(fs_lim)
   );

   assign op  = wr_data_in[zsd_pkg::OP_LSB +: zsd_pkg::OP_W];
   assign par = wr_data_in[0 +: zsd_pkg::PAR_W];
   assign cmd = wr_in && (addr_in == zsd_pkg::ADR_CMD);

   // Electrometer commands that pull the display back to the meter
   assign meter_cmd = cmd && (op == zsd_pkg::OP_FUNC || op == zsd_pkg::OP_RANGE ||
                              op == zsd_pkg::OP_CHECK || op == zsd_pkg::OP_CORR ||
                              op == zsd_pkg::OP_SUPP || op == zsd_pkg::OP_TRIG);

   always_comb
   begin
      status = '0;
      status[zsd_pkg::ST_CHECK] = st_ff.chk;
      status[zsd_pkg::ST_CORR]  = st_ff.cor;
      status[zsd_pkg::ST_SUPP]  = st_ff.sup;
      status[zsd_pkg::ST_ARM]   = st_ff.sup_arm;
      status[zsd_pkg::ST_SRC]   = st_ff.src;
      status[zsd_pkg::ST_READY] = (st_ff.wt == zsd_pkg::ZSD_IDLE);
      status[zsd_pkg::ST_OVR]   = st_ff.ovr;
      status[zsd_pkg::ST_RMODE +: 4] = st_ff.rmode;
      status[zsd_pkg::ST_RNG +: 4]   = st_ff.rng;
      status[zsd_pkg::ST_FUNC +: 3]  = st_ff.func;
      status[zsd_pkg::ST_TRIG +: 3]  = st_ff.trig;
   end

   // Reading path: offset, then baseline
   always_comb
   begin
      corr = $signed(conv_data_in);
      if (st_ff.cor)
      begin
         corr = $signed(conv_data_in) - st_ff.ofs;
      end
      res = corr;
      if (st_ff.sup)
      begin
         res = corr - st_ff.base;
      end
      mag = res[DW-1] ? -res : res;
      over = (mag >= fs_lim);
      // A fixed range below the baseline range cannot hold the baseline
      if (st_ff.sup && st_ff.rmode != zsd_pkg::RNG_AUTO && st_ff.rng < st_ff.base_rng)
      begin
         over = 1'b1;
      end
      auto_up = over && st_ff.rmode == zsd_pkg::RNG_AUTO && st_ff.rng < zsd_pkg::RNG_HIGH;
   end

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rup = 1'b0;
      nxt_st.vld = 1'b0;
      nxt_st.vexp = calc_exp;
      nxt_st.rdata = '0;

      // Read data stand in the cycle after the strobe only
      if (rd_in)
      begin
         case (addr_in)
            zsd_pkg::ADR_STATUS: nxt_st.rdata = status;
            zsd_pkg::ADR_RDG:    nxt_st.rdata = 32'(st_ff.rdg);
            zsd_pkg::ADR_BASE:   nxt_st.rdata = 32'(st_ff.base);
            zsd_pkg::ADR_OFS:    nxt_st.rdata = 32'(st_ff.ofs);
            default:             nxt_st.rdata = '0;
         endcase
      end

      // Readiness waits
      case (st_ff.wt)
         zsd_pkg::ZSD_IDLE:  nxt_st.wt = zsd_pkg::ZSD_IDLE;
         zsd_pkg::ZSD_WCONV:
         begin
            if (conv_done_in)
            begin
               nxt_st.wt = zsd_pkg::ZSD_IDLE;
            end
         end
         zsd_pkg::ZSD_WFE:
         begin
            if (fe_setup_done_in)
            begin
               nxt_st.wt = zsd_pkg::ZSD_IDLE;
            end
         end
         zsd_pkg::ZSD_WRNG:
         begin
            if (rng_setup_done_in)
            begin
               nxt_st.wt = zsd_pkg::ZSD_IDLE;
            end
         end
         default:            nxt_st.wt = zsd_pkg::ZSD_IDLE;
      endcase

      // Conversion results
      if (conv_done_in)
      begin
         nxt_st.vld = 1'b1;
         if (st_ff.cor_arm)
         begin
            // Fresh offset taken from the raw input with check active
            nxt_st.ofs = $signed(conv_data_in);
            nxt_st.cor_arm = 1'b0;
            nxt_st.rdg = '0;
            nxt_st.ovr = 1'b0;
         end
         else if (st_ff.sup_arm)
         begin
            nxt_st.base = corr;
            nxt_st.base_rng = st_ff.rng;
            nxt_st.sup = 1'b1;
            nxt_st.sup_arm = 1'b0;
            nxt_st.rdg = '0;
            nxt_st.ovr = 1'b0;
         end
         else
         begin
            nxt_st.rdg = res;
            nxt_st.ovr = over && !auto_up;
            if (auto_up)
            begin
               // Step up rather than report overrange
               nxt_st.rng = st_ff.rng + 4'h1;
               nxt_st.rup = 1'b1;
            end
         end
      end

      // Commands; a command in the same cycle as a result overrides it
      if (cmd)
      begin
         case (op)
            zsd_pkg::OP_CHECK:
            begin
               if (par == zsd_pkg::PAR_OFF || par == zsd_pkg::PAR_ON)
               begin
                  nxt_st.chk = (par == zsd_pkg::PAR_ON);
                  nxt_st.wt = zsd_pkg::ZSD_WFE;
               end
            end
            zsd_pkg::OP_CORR:
            begin
               if (par == zsd_pkg::PAR_OFF)
               begin
                  nxt_st.cor = 1'b0;
                  nxt_st.cor_arm = 1'b0;
                  nxt_st.wt = zsd_pkg::ZSD_WCONV;
               end
               else if (par == zsd_pkg::PAR_ON)
               begin
                  nxt_st.cor = 1'b1;
                  // Without check, the old offset stays in use
                  nxt_st.cor_arm = st_ff.chk;
                  nxt_st.wt = zsd_pkg::ZSD_WCONV;
               end
            end
            zsd_pkg::OP_RANGE:
            begin
               if (par == zsd_pkg::RNG_AUTO || par == zsd_pkg::RNG_FREEZE)
               begin
                  nxt_st.rmode = par;
                  nxt_st.wt = zsd_pkg::ZSD_WRNG;
               end
               else if (par <= zsd_pkg::RNG_HIGH)
               begin
                  nxt_st.rmode = par;
                  nxt_st.rng = par;
                  nxt_st.rup = 1'b0;
                  nxt_st.wt = zsd_pkg::ZSD_WRNG;
               end
            end
            zsd_pkg::OP_SUPP:
            begin
               if (par == zsd_pkg::PAR_OFF)
               begin
                  nxt_st.sup = 1'b0;
                  nxt_st.sup_arm = 1'b0;
               end
               else if (par == zsd_pkg::PAR_ON)
               begin
                  // Baseline comes from the next triggered conversion
                  nxt_st.sup_arm = !st_ff.sup;
               end
            end
            zsd_pkg::OP_FUNC:
            begin
               if (par[2:0] <= zsd_pkg::FUNC_MAX && par[3] == 1'b0)
               begin
                  nxt_st.func = par[2:0];
                  if (par[2:0] != st_ff.func)
                  begin
                     nxt_st.sup = 1'b0;
                     nxt_st.sup_arm = 1'b0;
                     nxt_st.base = '0;
                  end
               end
            end
            zsd_pkg::OP_TRIG:
            begin
               // Trigger mode is only held here for status
               nxt_st.trig = par[2:0];
            end
            zsd_pkg::OP_DISP:
            begin
               if (par == zsd_pkg::PAR_OFF || par == zsd_pkg::PAR_ON)
               begin
                  nxt_st.src = (par == zsd_pkg::PAR_ON);
               end
            end
            zsd_pkg::OP_CLEAR:
            begin
               nxt_st.chk = 1'b1;
               nxt_st.cor = 1'b0;
               nxt_st.cor_arm = 1'b0;
               nxt_st.src = 1'b0;
               nxt_st.rmode = zsd_pkg::RNG_AUTO;
               nxt_st.sup = 1'b0;
               nxt_st.sup_arm = 1'b0;
               nxt_st.wt = zsd_pkg::ZSD_IDLE;
               nxt_st.ovr = 1'b0;
            end
            default:
            begin
               nxt_st.wt = st_ff.wt;
            end
         endcase
         if (meter_cmd)
         begin
            nxt_st.src = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         st_ff <= '{wt: zsd_pkg::ZSD_IDLE, chk: 1'b1, rmode: zsd_pkg::RNG_AUTO,
                    rng: zsd_pkg::RNG_LOW, base_rng: zsd_pkg::RNG_LOW, default: '0};
      end
      else if (ce_in)
      begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data_out        = st_ff.rdata;
   assign zero_check_out     = st_ff.chk;
   assign offset_correct_out = st_ff.cor;
   assign suppress_out       = st_ff.sup;
   assign show_source_out    = st_ff.src;
   assign range_out          = st_ff.rng;
   assign vi_exp_out         = st_ff.vexp;
   // Idle wait state is the one-hot bit zero
   assign ready_out          = st_ff.wt[0];
   assign reading_out        = st_ff.rdg;
   assign reading_vld_out    = st_ff.vld;
   assign overrange_out      = st_ff.ovr;
   assign range_up_out       = st_ff.rup;
endmodule : zsd_top
`default_nettype wire

// ### tb/zsd_top_asserts.sv
// Port-level assertions of the zero, suppress and display mode block
`timescale 1ns/1ps
`default_nettype none
module zsd_top_asserts (
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   // Stimulus
   input wire logic        ce_in,
   input wire logic [7:0]  addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic        wr_in,
   input wire logic        conv_done_in,
   input wire logic        fe_setup_done_in,
   input wire logic        rng_setup_done_in,
   // Mode state
   input wire logic        zero_check_out,
   input wire logic        offset_correct_out,
   input wire logic        suppress_out,
   input wire logic        show_source_out,
   input wire logic [3:0]  range_out,
   input wire logic        ready_out,
   input wire logic        overrange_out,
   input wire logic        range_up_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_cmd(logic [3:0] op);
      ce_in && wr_in && addr_in == zsd_pkg::ADR_CMD && wr_data_in[11:8] == op;
   endsequence
   // Only parameters 0 and 1 are legal for the on/off commands
   sequence s_bin(logic [3:0] op);
      s_cmd(op) ##0 (wr_data_in[3:1] == 3'h0);
   endsequence
   sequence s_meter_cmd;
      ce_in && wr_in && addr_in == zsd_pkg::ADR_CMD && wr_data_in[11:8] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
   endsequence
   // Reset must land even though the default disable would hide it
   property p_rst;
      disable iff (1'b0) !rst_n_in |=> zero_check_out && !offset_correct_out && !suppress_out && !show_source_out;
   endproperty
   property p_check;
      s_bin(zsd_pkg::OP_CHECK) |=> zero_check_out == $past(wr_data_in[0]);
   endproperty
   property p_corr;
      s_bin(zsd_pkg::OP_CORR) |=> offset_correct_out == $past(wr_data_in[0]);
   endproperty
   property p_disp;
      s_bin(zsd_pkg::OP_DISP) |=> show_source_out == $past(wr_data_in[0]);
   endproperty
   property p_revert;
      s_meter_cmd |=> !show_source_out;
   endproperty
   property p_corr_wait;
      s_bin(zsd_pkg::OP_CORR) ##1 (!conv_done_in && !wr_in) |=> !ready_out;
   endproperty
   property p_check_wait;
      s_bin(zsd_pkg::OP_CHECK) ##1 (!fe_setup_done_in && !wr_in) |=> !ready_out;
   endproperty
   property p_rng_wait;
      s_cmd(zsd_pkg::OP_RANGE) ##0 (wr_data_in[3:0] <= 4'hC) ##1 (!rng_setup_done_in && !wr_in) |=> !ready_out;
   endproperty
   property p_rdy_cause;
      $past(rst_n_in) && $rose(ready_out) |-> $past(conv_done_in || fe_setup_done_in || rng_setup_done_in
         || (wr_in && wr_data_in[11:8] == zsd_pkg::OP_CLEAR));
   endproperty
   property p_rng_set;
      s_cmd(zsd_pkg::OP_RANGE) ##0 (wr_data_in[3:0] inside {[1:11]}) |=> range_out == $past(wr_data_in[3:0]);
   endproperty
   property p_rng_up;
      range_up_out |-> !overrange_out && range_out == $past(range_out) + 4'h1;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   a_check: assert property (p_check) else $error("check command not decoded");
   a_corr: assert property (p_corr) else $error("correct command not decoded");
   a_disp: assert property (p_disp) else $error("display command not decoded");
   a_revert: assert property (p_revert) else $error("display did not revert");
   a_corr_wait: assert property (p_corr_wait) else $error("ready before reading done");
   a_check_wait: assert property (p_check_wait) else $error("ready before front end setup");
   a_rng_wait: assert property (p_rng_wait) else $error("ready before range setup");
   a_rdy_cause: assert property (p_rdy_cause) else $error("ready rose without cause");
   a_rng_set: assert property (p_rng_set) else $error("fixed range not taken");
   a_rng_up: assert property (p_rng_up) else $error("autorange step wrong");
endmodule : zsd_top_asserts
bind zsd_top zsd_top_asserts zsd_top_asserts_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .conv_done_in(conv_done_in),
   .fe_setup_done_in(fe_setup_done_in), .rng_setup_done_in(rng_setup_done_in), .zero_check_out(zero_check_out),
   .offset_correct_out(offset_correct_out), .suppress_out(suppress_out), .show_source_out(show_source_out),
   .range_out(range_out), .ready_out(ready_out), .overrange_out(overrange_out), .range_up_out(range_up_out));
`default_nettype wire

// ### tb/zsd_host.sv
// Host controller model driving the command register port
`timescale 1ns/1ps
`default_nettype none
module zsd_host (
   // Clock
   input  wire logic        clk_in,
   // Register port
   output logic [7:0]       addr_out,
   output logic [31:0]      wr_data_out,
   output logic             wr_out,
   output logic             rd_out,
   input  wire logic [31:0] rd_data_in
);
   initial
   begin
      addr_out = 8'h00;
      wr_data_out = 32'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic cmd(input logic [3:0] op, input logic [3:0] par);
      @(posedge clk_in);
      wr_out <= 1'b1;
      addr_out <= zsd_pkg::ADR_CMD;
      wr_data_out <= {20'h0, op, 4'h0, par};
      @(posedge clk_in);
      wr_out <= 1'b0;
      // Idle data is scrambled so nothing leans on a stale word
      wr_data_out <= ~wr_data_out;
   endtask : cmd
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      rd_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rd_data_in;
   endtask : rd
endmodule : zsd_host
`default_nettype wire

// ### tb/zsd_top_tb.sv
// Self-checking bench of the zero, suppress and display mode block
`timescale 1ns/1ps
`default_nettype none
module zsd_top_tb;
   logic        clk_in, rst_n_in, ce_in, wr_in, rd_in, conv_done_in, fe_setup_done_in, rng_setup_done_in;
   logic [7:0]  addr_in;
   logic [31:0] wr_data_in, rd_data_out, st;
   logic [23:0] conv_data_in, reading_out;
   logic [3:0]  range_out;
   logic [4:0]  vi_exp_out;
   logic        zero_check_out, offset_correct_out, suppress_out, show_source_out, ready_out;
   logic        reading_vld_out, overrange_out, range_up_out;
   int          error_cnt, n_tests, m_corr, m_supp, m_ofs, m_base, r;
   zsd_top #(.DW(24)) zsd_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
      .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .fe_setup_done_in(fe_setup_done_in),
      .rng_setup_done_in(rng_setup_done_in), .zero_check_out(zero_check_out),
      .offset_correct_out(offset_correct_out), .suppress_out(suppress_out), .show_source_out(show_source_out),
      .range_out(range_out), .vi_exp_out(vi_exp_out), .ready_out(ready_out), .reading_out(reading_out),
      .reading_vld_out(reading_vld_out), .overrange_out(overrange_out), .range_up_out(range_up_out));
   zsd_host zsd_host_inst (.clk_in(clk_in), .addr_out(addr_in), .wr_data_out(wr_data_in), .wr_out(wr_in),
      .rd_out(rd_in), .rd_data_in(rd_data_out));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic cmd(input logic [3:0] op, input logic [3:0] p);
      zsd_host_inst.cmd(op, p);
      #1;
   endtask : cmd
   task automatic wait_rdy;
      for (int i = 0; i < 20 && ready_out !== 1'b1; i++)
      begin
         @(posedge clk_in);
         #1;
      end
      if (ready_out !== 1'b1)
      begin
         chk("ready_out", 32'(ready_out), 32'h1);
         complete_run();
      end
   endtask : wait_rdy
   task automatic front(input logic fe, input logic rg);
      chk("ready_out", 32'(ready_out), 32'h0);
      @(posedge clk_in);
      fe_setup_done_in <= fe;
      rng_setup_done_in <= rg;
      @(posedge clk_in);
      fe_setup_done_in <= 1'b0;
      rng_setup_done_in <= 1'b0;
      wait_rdy();
   endtask : front
   // Capture kinds: 0 plain reading, 1 offset capture, 2 baseline capture
   task automatic conv(input int d, input int cap);
      int e;
      e = (cap != 0) ? 0 : d - (m_corr != 0 ? m_ofs : 0) - (m_supp != 0 ? m_base : 0);
      if (cap == 1)
         m_ofs = d;
      if (cap == 2)
         m_base = d - (m_corr != 0 ? m_ofs : 0);
      @(posedge clk_in);
      conv_done_in <= 1'b1;
      conv_data_in <= d[23:0];
      @(posedge clk_in);
      conv_done_in <= 1'b0;
      conv_data_in <= ~d[23:0];
      #1;
      chk("reading_vld_out", 32'(reading_vld_out), 32'h1);
      chk("reading_out", 32'(signed'(reading_out)), e);
   endtask : conv
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial
   begin
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      conv_done_in = 1'b0;
      conv_data_in = 24'h0;
      fe_setup_done_in = 1'b0;
      rng_setup_done_in = 1'b0;
      {error_cnt, n_tests, m_corr, m_supp, m_ofs, m_base} = '0;
      void'($urandom(32'h648D));
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk("zero_check_out", 32'(zero_check_out), 32'h1);
      chk("offset_correct_out", 32'(offset_correct_out), 32'h0);
      chk("show_source_out", 32'(show_source_out), 32'h0);
      zsd_host_inst.rd(zsd_pkg::ADR_STATUS, st);
      chk("range_mode", 32'(st[zsd_pkg::ST_RMODE +: 4]), 32'h0);
      zsd_host_inst.rd(8'h14, st);
      chk("unmapped", st, 32'h0);
      $display("Test reset done");
      // Zeroing order: check on, correct on, check off
      cmd(zsd_pkg::OP_CHECK, zsd_pkg::PAR_ON);
      front(1'b1, 1'b0);
      cmd(zsd_pkg::OP_CORR, zsd_pkg::PAR_ON);
      m_corr = 1;
      chk("ready_out", 32'(ready_out), 32'h0);
      conv($urandom_range(1, 300), 1);
      wait_rdy();
      zsd_host_inst.rd(zsd_pkg::ADR_OFS, st);
      chk("offset", st, m_ofs);
      cmd(zsd_pkg::OP_CHECK, zsd_pkg::PAR_OFF);
      front(1'b1, 1'b0);
      conv($urandom_range(0, 5000), 0);
      cmd(zsd_pkg::OP_CORR, zsd_pkg::PAR_OFF);
      m_corr = 0;
      conv($urandom_range(0, 5000), 0);
      cmd(zsd_pkg::OP_CORR, zsd_pkg::PAR_ON);
      m_corr = 1;
      conv($urandom_range(0, 5000), 0);
      $display("Test zero done");
      for (r = 1; r <= 12; r++)
      begin
         cmd(zsd_pkg::OP_RANGE, r[3:0]);
         front(1'b0, 1'b1);
         chk("range_out", 32'(range_out), r < 12 ? r : 11);
         chk("vi_exp_out", 32'(vi_exp_out), r < 11 ? 15 - r : 5);
      end
      $display("Test range done");
      cmd(zsd_pkg::OP_TRIG, 4'h1);
      cmd(zsd_pkg::OP_SUPP, zsd_pkg::PAR_OFF);
      cmd(zsd_pkg::OP_RANGE, 4'h5);
      front(1'b0, 1'b1);
      cmd(zsd_pkg::OP_SUPP, zsd_pkg::PAR_ON);
      conv($urandom_range(100, 3000), 2);
      m_supp = 1;
      chk("suppress_out", 32'(suppress_out), 32'h1);
      zsd_host_inst.rd(zsd_pkg::ADR_BASE, st);
      chk("baseline", st, m_base);
      conv($urandom_range(0, 9000), 0);
      conv(m_ofs + m_base + 20000, 0);
      chk("overrange_out", 32'(overrange_out), 32'h1);
      cmd(zsd_pkg::OP_RANGE, 4'h4);
      front(1'b0, 1'b1);
      conv(m_ofs + m_base + 10, 0);
      chk("overrange_out", 32'(overrange_out), 32'h1);
      cmd(zsd_pkg::OP_FUNC, 4'h5);
      m_supp = 0;
      chk("suppress_out", 32'(suppress_out), 32'h0);
      conv($urandom_range(0, 9000), 0);
      $display("Test suppress done");
      cmd(zsd_pkg::OP_RANGE, zsd_pkg::RNG_AUTO);
      front(1'b0, 1'b1);
      conv(m_ofs + 25000, 0);
      chk("range_up_out", 32'(range_up_out), 32'h1);
      chk("overrange_out", 32'(overrange_out), 32'h0);
      chk("range_out", 32'(range_out), 32'h5);
      // Enable low must swallow a conversion pulse
      @(posedge clk_in);
      ce_in <= 1'b0;
      conv_done_in <= 1'b1;
      @(posedge clk_in);
      ce_in <= 1'b1;
      conv_done_in <= 1'b0;
      #1;
      chk("frozen_vld", 32'(reading_vld_out), 32'h0);
      chk("frozen_reading", 32'(signed'(reading_out)), 32'h61A8);
      chk("frozen_range", 32'(range_out), 32'h5);
      $display("Test autorange done");
      for (r = 1; r <= 7; r++)
      begin
         if (r inside {1, 2, 3, 4, 5, 7})
         begin
            cmd(zsd_pkg::OP_DISP, zsd_pkg::PAR_ON);
            chk("show_source_out", 32'(show_source_out), 32'h1);
            cmd(4'(r), 4'hF);
            chk("show_source_out", 32'(show_source_out), 32'h0);
         end
      end
      $display("Test display done");
      cmd(zsd_pkg::OP_CORR, zsd_pkg::PAR_ON);
      cmd(zsd_pkg::OP_DISP, zsd_pkg::PAR_ON);
      cmd(zsd_pkg::OP_CLEAR, 4'h0);
      chk("zero_check_out", 32'(zero_check_out), 32'h1);
      chk("offset_correct_out", 32'(offset_correct_out), 32'h0);
      chk("show_source_out", 32'(show_source_out), 32'h0);
      chk("ready_out", 32'(ready_out), 32'h1);
      zsd_host_inst.rd(zsd_pkg::ADR_STATUS, st);
      chk("range_mode", 32'(st[zsd_pkg::ST_RMODE +: 4]), 32'h0);
      $display("Test clear done");
      complete_run();
   end
endmodule : zsd_top_tb
`default_nettype wire
